// File: design/logic_and_cond_branch_exec.sv
/*
 * Top of the execution slice: AXI4-Lite slave, instruction sequencer with
 * program counter, carry flag, immediate prefix and branch delay slot.
 * Assumes software acts as the fetch stage, issuing one word at a time
 * through the instruction register and reading the program counter back.
 */
// Local design decisions: the register offsets and register access over AXI4-Lite.
//
// Notes on behaviour
// RQ1: add-immediate sums source and extended immediate, plus carry flag when carry-use set.
// RQ2: keep-carry bit 3 set leaves carry flag; clear writes adder carry-out.
// RQ3: opcode bit 4 selects carry use; clear means carry flag is ignored.
// RQ4: carry-use opcode bit and status carry flag are separate things.
// RQ5: register-immediate forms sign-extend the 16-bit field to 32 bits.
// RQ6: an immediately preceding prefix instruction supplies the upper half instead.
// RQ7: register AND writes first AND second source; one cycle; nothing else changes.
// RQ8: immediate AND writes first source AND sign-extended immediate.
// RQ9: register AND-NOT, opcode 100011, writes first source AND complement of second.
// RQ10: immediate AND-NOT writes first source AND complement of extended immediate.
// RQ11: register branch-if-equal jumps to pc plus offset register when tested is zero.
// RQ12: immediate branch-if-equal jumps to pc plus extended immediate when tested is zero.
// RQ13: greater-or-equal branches taken when tested register, signed, is not negative.
// RQ14: untaken branch advances pc by four; branches change only the pc.
// RQ15: delayed mnemonics carry the delay-slot bit; plain ones have it clear.
// RQ16: with delay slot, the following instruction completes before the target.
// RQ17: without delay slot, a taken branch goes straight to the target.
// RQ18: branch latency: one cycle untaken, two taken delayed, three taken plain.
// RQ19: branch test sees the value just written by the preceding instruction.
`default_nettype none
module logic_and_cond_branch_exec
	import exec_pkg::*;
(
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// write address channel
	input  wire logic [exec_pkg::ADDR_W-1:0]   awaddr,
	input  wire logic [2:0]                    awprot,
	input  wire logic                          awvalid,
	output logic                               awready,
	// write data channel
	input  wire logic [exec_pkg::XLEN-1:0]     wdata,
	input  wire logic [exec_pkg::STRB_W-1:0]   wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	// write response channel
	output logic      [1:0]                    bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	// read address channel
	input  wire logic [exec_pkg::ADDR_W-1:0]   araddr,
	input  wire logic [2:0]                    arprot,
	input  wire logic                          arvalid,
	output logic                               arready,
	// read data channel
	output logic      [exec_pkg::XLEN-1:0]     rdata,
	output logic      [1:0]                    rresp,
	output logic                               rvalid,
	input  wire logic                          rready
);
	import exec_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_EXEC, S_STALL} state_t;

	state_t            state;
	logic [1:0]        cnt;
	logic [ADDR_W-1:0] aw_addr;
	logic [XLEN-1:0]   w_data;
	logic [STRB_W-1:0] w_strb;
	logic [XLEN-1:0]   wmask;
	logic              wr_fire;
	logic [1:0]        next_bresp;
	logic              sw_issue;
	logic              sw_pc_we;
	logic              sw_stat_we;
	logic              sw_sel_we;
	logic              sw_reg_we;
	logic              busy;
	logic              exec_now;
	logic [XLEN-1:0]   dec_instr;
	logic [XLEN-1:0]   pc;
	logic              carry_flag;
	logic [IMMW-1:0]   imm_hi;
	logic              imm_valid;
	logic              slot_pend;
	logic [XLEN-1:0]   slot_target;
	logic              illegal;
	logic [REGW-1:0]   sel;
	logic [XLEN-1:0]   ra_val;
	logic [XLEN-1:0]   rb_val;
	logic [XLEN-1:0]   dbg_val;
	logic              rf_we;
	logic [REGW-1:0]   rf_widx;
	logic [XLEN-1:0]   rf_wdata;
	logic [XLEN-1:0]   status;
	logic [XLEN-1:0]   rd_val;
	logic [1:0]        rd_resp;

	exec_if ex ();

	exec_unit u_exec (
		.ex (ex)
	);

	// results are written at the end of the execute cycle, so the next
	// instruction's read ports already see them without a bypass path
	gp_regfile u_regs (
		.clk     (sys_clk),
		.rst_n   (rst_n),
		.ra_idx  (dec_instr[RA_HI:RA_LO]), // RQ19
		.rb_idx  (dec_instr[RB_HI:RB_LO]),
		.dbg_idx (sel),
		.ra_val  (ra_val),
		.rb_val  (rb_val),
		.dbg_val (dbg_val),
		.we      (rf_we),
		.widx    (rf_widx),
		.wdata   (rf_wdata)
	);

	assign busy     = (state != S_IDLE);
	assign exec_now = (state == S_EXEC);
	assign wr_fire  = ~awready & ~wready & ~bvalid;

	for (genvar i = 0; i < STRB_W; i++) begin : g_lane
		assign wmask[i*8 +: 8] = {8{w_strb[i]}};
	end

	assign ex.instr     = dec_instr;
	assign ex.pc        = pc;
	assign ex.op_a      = ra_val;
	assign ex.op_b      = rb_val;
	assign ex.carry_in  = carry_flag;
	assign ex.imm_hi    = imm_hi;
	assign ex.imm_valid = imm_valid;

	// only branch-free results reach the register file
	assign rf_we    = (exec_now & ex.res_we) | sw_reg_we; // RQ14
	assign rf_widx  = exec_now ? dec_instr[RD_HI:RD_LO] : sel;
	assign rf_wdata = exec_now ? ex.result : ((dbg_val & ~wmask) | (w_data & wmask));

	// write decode; everything but the select register is refused mid-instruction
	always_comb begin
		sw_issue   = 1'b0;
		sw_pc_we   = 1'b0;
		sw_stat_we = 1'b0;
		sw_sel_we  = 1'b0;
		sw_reg_we  = 1'b0;
		next_bresp = RESP_OKAY;
		if (wr_fire) begin
			case (aw_addr)
				REG_INSTR: begin
					// a partial instruction word makes no sense, so refuse it
					if (busy || w_strb != {STRB_W{1'b1}})
						next_bresp = RESP_SLVERR;
					else
						sw_issue = 1'b1;
				end
				REG_PC: begin
					if (busy)
						next_bresp = RESP_SLVERR;
					else
						sw_pc_we = 1'b1;
				end
				REG_STATUS: begin
					if (busy)
						next_bresp = RESP_SLVERR;
					else
						sw_stat_we = 1'b1;
				end
				REG_SEL: sw_sel_we = w_strb[0];
				REG_DATA: begin
					if (busy)
						next_bresp = RESP_SLVERR;
					else
						sw_reg_we = 1'b1;
				end
				default: next_bresp = RESP_DECERR;
			endcase
		end
	end

	// write channels: address and data may arrive in either order
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_addr <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
				wready <= 1'b0;
			end
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= next_bresp;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		status             = '0;
		status[ST_CARRY]   = carry_flag;
		status[ST_BUSY]    = busy;
		status[ST_IMMP]    = imm_valid;
		status[ST_SLOT]    = slot_pend;
		status[ST_ILLEGAL] = illegal;
		rd_resp            = RESP_OKAY;
		case (araddr)
			REG_INSTR:  rd_val = dec_instr;
			REG_PC:     rd_val = pc;
			REG_STATUS: rd_val = status;
			REG_SEL:    rd_val = {{(XLEN-REGW){1'b0}}, sel};
			REG_DATA:   rd_val = dbg_val;
			default: begin
				rd_val  = '0;
				rd_resp = RESP_DECERR;
			end
		endcase
	end

	// read channels
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_val;
			rresp   <= rd_resp;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// sequencer: one execute cycle, then stall out the rest of the latency
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			cnt   <= '0;
		end else begin
			case (state)
				S_IDLE: begin
					if (sw_issue)
						state <= S_EXEC;
				end
				S_EXEC: begin
					cnt <= ex.lat - LAT_ONE; // RQ18
					if (ex.lat != LAT_ONE)
						state <= S_STALL;
					else
						state <= S_IDLE;
				end
				S_STALL: begin
					cnt <= cnt - LAT_ONE;
					if (cnt == LAT_ONE)
						state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			dec_instr <= '0;
		else if (sw_issue)
			dec_instr <= w_data;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			sel <= '0;
		else if (sw_sel_we)
			sel <= w_data[REGW-1:0];
	end

	// program counter; a pending delay-slot target outranks a branch in the slot
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			pc <= RESET_PC;
		else if (exec_now) begin
			if (slot_pend)
				pc <= slot_target; // RQ16
			else if (ex.taken && !dec_instr[DSLOT_BIT])
				pc <= ex.target; // RQ17
			else
				pc <= pc + PC_STEP; // RQ14
		end else if (sw_pc_we)
			pc <= (pc & ~wmask) | (w_data & wmask);
	end

	// delay slot: remember the target until the next instruction has run
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_pend   <= 1'b0;
			slot_target <= '0;
		end else if (exec_now) begin
			if (slot_pend)
				slot_pend <= 1'b0;
			else if (ex.taken && dec_instr[DSLOT_BIT]) begin
				slot_pend   <= 1'b1; // RQ15 RQ16
				slot_target <= ex.target;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			carry_flag <= 1'b0;
		else if (exec_now && ex.carry_we)
			carry_flag <= ex.carry_out; // RQ2
		else if (sw_stat_we)
			carry_flag <= w_data[ST_CARRY];
	end

	// prefix lives for exactly one following instruction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			imm_valid <= 1'b0;
			imm_hi    <= '0;
		end else if (exec_now) begin
			imm_valid <= ex.is_prefix; // RQ6
			if (ex.is_prefix)
				imm_hi <= dec_instr[IMM_HI:IMM_LO];
		end
	end

	// sticky; a new event beats a same-cycle clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			illegal <= 1'b0;
		else
			illegal <= (exec_now & ex.illegal) | (illegal & ~(sw_stat_we & w_data[ST_ILLEGAL]));
	end
endmodule
`default_nettype wire

// File: design/exec_pkg.sv
/*
 * Shared constants for the logic/branch execution slice: instruction fields,
 * opcodes, latencies and the register map seen over AXI4-Lite.
 * Assumes big-endian bit labels in the ISA: label 0 is word bit 31.
 */
`default_nettype none
package exec_pkg;
	localparam int XLEN   = 32;
	localparam int IMMW   = 16;
	localparam int REGW   = 5;
	localparam int NREG   = 32;
	localparam int ADDR_W = 8;
	localparam int STRB_W = XLEN / 8;

	// instruction fields
	localparam int OP_HI     = 31;
	localparam int OP_LO     = 26;
	localparam int RD_HI     = 25;
	localparam int RD_LO     = 21;
	localparam int RA_HI     = 20;
	localparam int RA_LO     = 16;
	localparam int RB_HI     = 15;
	localparam int RB_LO     = 11;
	localparam int IMM_HI    = 15;
	localparam int IMM_LO    = 0;
	localparam int KEEP_BIT  = 28;
	localparam int CUSE_BIT  = 27;
	localparam int DSLOT_BIT = 25;
	localparam int COND_HI   = 24;
	localparam int COND_LO   = 21;

	// opcodes
	localparam logic [5:0] OP_ADDI      = 6'h08;
	localparam logic [5:0] OP_ADDI_MASK = 6'h39;
	localparam logic [5:0] OP_AND       = 6'h21;
	localparam logic [5:0] OP_ANDN      = 6'h23;
	localparam logic [5:0] OP_ANDI      = 6'h29;
	localparam logic [5:0] OP_ANDNI     = 6'h2b;
	localparam logic [5:0] OP_BR_REG    = 6'h27;
	localparam logic [5:0] OP_BR_IMM    = 6'h2f;
	localparam logic [5:0] OP_IMM_PFX   = 6'h2c;
	localparam logic [3:0] COND_EQ      = 4'h0;
	localparam logic [3:0] COND_GE      = 4'h5;

	localparam logic [REGW-1:0] ZERO_REG = 5'h00;
	localparam logic [XLEN-1:0] PC_STEP  = 32'h0000_0004;
	localparam logic [XLEN-1:0] RESET_PC = 32'h0000_0000;

	// latencies in cycles
	localparam logic [1:0] LAT_ONE      = 2'h1;
	localparam logic [1:0] LAT_TAKEN_D  = 2'h2;
	localparam logic [1:0] LAT_TAKEN_ND = 2'h3;

	// register map (byte addresses)
	localparam logic [ADDR_W-1:0] REG_INSTR  = 8'h00;
	localparam logic [ADDR_W-1:0] REG_PC     = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SEL    = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_DATA   = 8'h10;

	// status bits
	localparam int ST_CARRY   = 0;
	localparam int ST_BUSY    = 1;
	localparam int ST_IMMP    = 2;
	localparam int ST_SLOT    = 3;
	localparam int ST_ILLEGAL = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

// File: design/exec_if.sv
/*
 * Bundle between the sequencing core and the combinational execute unit.
 * Assumes the core holds every operand stable for the execute cycle.
 */
`default_nettype none
interface exec_if;
	import exec_pkg::*;
	logic [XLEN-1:0] instr;
	logic [XLEN-1:0] pc;
	logic [XLEN-1:0] op_a;
	logic [XLEN-1:0] op_b;
	logic            carry_in;
	logic [IMMW-1:0] imm_hi;
	logic            imm_valid;
	logic [XLEN-1:0] result;
	logic            res_we;
	logic            carry_out;
	logic            carry_we;
	logic            taken;
	logic [XLEN-1:0] target;
	logic            is_prefix;
	logic            illegal;
	logic [1:0]      lat;

	modport core (output instr, pc, op_a, op_b, carry_in, imm_hi, imm_valid,
		input result, res_we, carry_out, carry_we, taken, target, is_prefix, illegal, lat);
	modport unit (input instr, pc, op_a, op_b, carry_in, imm_hi, imm_valid,
		output result, res_we, carry_out, carry_we, taken, target, is_prefix, illegal, lat);
endinterface
`default_nettype wire

// File: design/gp_regfile.sv
/*
 * General register file: three combinational read ports, one write port.
 * Assumes the caller never writes and reads the same entry expecting old data.
 */
`default_nettype none
module gp_regfile
	import exec_pkg::*;
(
	// clock and reset
	input  wire logic            clk,
	input  wire logic            rst_n,
	// read ports
	input  wire logic [REGW-1:0] ra_idx,
	input  wire logic [REGW-1:0] rb_idx,
	input  wire logic [REGW-1:0] dbg_idx,
	output logic      [XLEN-1:0] ra_val,
	output logic      [XLEN-1:0] rb_val,
	output logic      [XLEN-1:0] dbg_val,
	// write port
	input  wire logic            we,
	input  wire logic [REGW-1:0] widx,
	input  wire logic [XLEN-1:0] wdata
);
	logic [XLEN-1:0] mem [NREG];

	// entry zero never takes a write, so it reads as zero
	for (genvar i = 0; i < NREG; i++) begin : g_ent
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				mem[i] <= '0;
			else if (we && widx == REGW'(i) && widx != ZERO_REG)
				mem[i] <= wdata;
		end
	end

	assign ra_val  = mem[ra_idx];
	assign rb_val  = mem[rb_idx];
	assign dbg_val = mem[dbg_idx];
endmodule
`default_nettype wire

// File: design/exec_unit.sv
/*
 * Combinational execute unit: add-immediate, the AND family and the
 * equal / greater-or-equal branches. Assumes operands are already forwarded.
 */
`default_nettype none
module exec_unit
	import exec_pkg::*;
(
	exec_if.unit ex
);
	logic [5:0]      opc;
	logic [IMMW-1:0] imm16;
	logic [XLEN-1:0] imm_ext;
	logic [XLEN-1:0] offset;
	logic [XLEN:0]   sum;
	logic            cin;
	logic            hit;

	always_comb begin
		opc   = ex.instr[OP_HI:OP_LO];
		imm16 = ex.instr[IMM_HI:IMM_LO];
		// prefixed word replaces the sign extension
		if (ex.imm_valid)
			imm_ext = {ex.imm_hi, imm16}; // RQ6
		else
			imm_ext = {{(XLEN-IMMW){imm16[IMMW-1]}}, imm16}; // RQ5
		// opcode carry-use bit gates the status carry, never the reverse
		cin = ex.instr[CUSE_BIT] & ex.carry_in; // RQ3 RQ4
		sum = {1'b0, ex.op_a} + {1'b0, imm_ext} + {{XLEN{1'b0}}, cin}; // RQ1
		offset = (opc == OP_BR_REG) ? ex.op_b : imm_ext;
		ex.target = ex.pc + offset; // RQ11 RQ12
		hit = 1'b0;
		case (ex.instr[COND_HI:COND_LO])
			COND_EQ: hit = (ex.op_a == '0); // RQ11 RQ12
			COND_GE: hit = ~ex.op_a[XLEN-1]; // RQ13
			default: hit = 1'b0;
		endcase

		ex.result    = '0;
		ex.res_we    = 1'b0;
		ex.carry_out = sum[XLEN];
		ex.carry_we  = 1'b0;
		ex.taken     = 1'b0;
		ex.is_prefix = 1'b0;
		ex.illegal   = 1'b0;
		ex.lat       = LAT_ONE; // RQ7
		if ((opc & OP_ADDI_MASK) == OP_ADDI) begin
			ex.result   = sum[XLEN-1:0];
			ex.res_we   = 1'b1;
			ex.carry_we = ~ex.instr[KEEP_BIT]; // RQ2
		end else begin
			case (opc)
				OP_AND: begin
					ex.result = ex.op_a & ex.op_b; // RQ7
					ex.res_we = 1'b1;
				end
				OP_ANDN: begin
					ex.result = ex.op_a & ~ex.op_b; // RQ9
					ex.res_we = 1'b1;
				end
				OP_ANDI: begin
					ex.result = ex.op_a & imm_ext; // RQ8
					ex.res_we = 1'b1;
				end
				OP_ANDNI: begin
					ex.result = ex.op_a & ~imm_ext; // RQ10
					ex.res_we = 1'b1;
				end
				OP_BR_REG, OP_BR_IMM: begin
					// conditions other than equal and greater-or-equal are not built here
					ex.illegal = ~(ex.instr[COND_HI:COND_LO] == COND_EQ ||
						ex.instr[COND_HI:COND_LO] == COND_GE);
					ex.taken = hit;
					if (!hit)
						ex.lat = LAT_ONE; // RQ18
					else if (ex.instr[DSLOT_BIT])
						ex.lat = LAT_TAKEN_D; // RQ18
					else
						ex.lat = LAT_TAKEN_ND; // RQ18
				end
				OP_IMM_PFX: ex.is_prefix = 1'b1;
				default: ex.illegal = 1'b1;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: tb/exec_props.sv
/*
 * Bus-level checker for the execution slice top.
 * Assumes it is bound to the top and sees only its AXI4-Lite ports.
 */
`default_nettype none
module exec_props (
	// clock and reset
	input wire logic                      sys_clk,
	input wire logic                      rst_n,
	// write side
	input wire logic                      awvalid,
	input wire logic                      awready,
	input wire logic                      wvalid,
	input wire logic                      wready,
	input wire logic [1:0]                bresp,
	input wire logic                      bvalid,
	input wire logic                      bready,
	// read side
	input wire logic                      arvalid,
	input wire logic                      arready,
	input wire logic [exec_pkg::XLEN-1:0] rdata,
	input wire logic [1:0]                rresp,
	input wire logic                      rvalid,
	input wire logic                      rready
);
	timeunit 1ns;
	timeprecision 1ns;
	import exec_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped or changed while stalled");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped or changed while stalled");
	a_read_turn: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer not one cycle after address");
	a_write_turn: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response not two edges after handshake");
	a_addr_block: assert property (bvalid |-> !awready && !wready)
		else $error("write channels open while response pending");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("read address open while data pending");
	a_b_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write response not released after bready");
	a_r_release: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read data not released after rready");
	a_resp_codes: assert property (rvalid |-> (rresp == RESP_OKAY || rresp == RESP_DECERR))
		else $error("illegal read response code");
	c_write: cover property (awvalid && awready && wvalid && wready);
	c_slverr: cover property (bvalid && bready && bresp == RESP_SLVERR);
	c_decerr: cover property (rvalid && rready && rresp == RESP_DECERR);
endmodule
bind logic_and_cond_branch_exec exec_props exec_props_inst (.sys_clk, .rst_n, .awvalid, .awready, .wvalid,
	.wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
`default_nettype wire

// File: tb/axi_host.sv
/*
 * Software side of the slice: an AXI4-Lite master with one write and one read task.
 * Assumes a single caller; released payloads are inverted so stale data never matches.
 */
`default_nettype none
module axi_host (
	// clock
	input wire logic                        sys_clk,
	// write channels
	output logic      [exec_pkg::ADDR_W-1:0] awaddr,
	output logic                             awvalid,
	input  wire logic                        awready,
	output logic      [exec_pkg::XLEN-1:0]   wdata,
	output logic      [exec_pkg::STRB_W-1:0] wstrb,
	output logic                             wvalid,
	input  wire logic                        wready,
	input  wire logic                        bvalid,
	output logic                             bready,
	// read channels
	output logic      [exec_pkg::ADDR_W-1:0] araddr,
	output logic                             arvalid,
	input  wire logic                        arready,
	input  wire logic [exec_pkg::XLEN-1:0]   rdata,
	input  wire logic                        rvalid,
	output logic                             rready
);
	timeunit 1ns;
	timeprecision 1ns;
	import exec_pkg::*;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// ready rises with the request; one idle edge after each answer keeps calls apart
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [XLEN-1:0] d, input logic [STRB_W-1:0] s);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (!bvalid);
		bready <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [XLEN-1:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking bench: AND family, add-immediate carry, prefix and branches, all through the bus.
 * Assumes the host model drives the bus; a monitor checks each answer against queued notes.
 */
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import exec_pkg::*;
	typedef struct packed {logic [31:0] m; logic [31:0] v; logic [1:0] rs;} note_t;
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [2:0]        prot = 3'h0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [XLEN-1:0]   wdata, rdata, seed = 32'h7c04, pc, a, b, x, tv, off, tgt, st;
	logic [STRB_W-1:0] wstrb;
	logic [1:0]        bresp, rresp;
	logic [15:0]       im;
	logic [3:0]        cond;
	logic              co, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int                n_fail = 0, cmp_count = 0, cycles = 0;
	note_t             exp_r[$];
	logic [1:0]        exp_b[$];

	always #25 sys_clk = ~sys_clk;
	logic_and_cond_branch_exec logic_and_cond_branch_exec_inst (.sys_clk, .rst_n, .awaddr, .awprot(prot),
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arprot(prot), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	axi_host axi_host_inst (.sys_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready);

	function automatic logic [31:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [31:0] ins(input logic [5:0] op, input logic [4:0] d, input logic [4:0] s,
		input logic [15:0] lo);
		return {op, d, s, lo};
	endfunction
	task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
		exp_b.push_back(r);
		axi_host_inst.wr(ad, d, s);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] v, input logic [1:0] r);
		logic [31:0] d;
		exp_r.push_back('{m, v, r});
		axi_host_inst.rd(ad, d);
	endtask
	task automatic put(input logic [4:0] i, input logic [31:0] v);
		wr(REG_SEL, {27'h0, i}, 4'hf, RESP_OKAY);
		wr(REG_DATA, v, 4'hf, RESP_OKAY);
	endtask
	task automatic get(input logic [4:0] i, input logic [31:0] v);
		wr(REG_SEL, {27'h0, i}, 4'hf, RESP_OKAY);
		rd(REG_DATA, 32'hffff_ffff, v, RESP_OKAY);
	endtask
	// busy polling only steers the sequence; its data is not judged
	task automatic issue(input logic [31:0] w);
		wr(REG_INSTR, w, 4'hf, RESP_OKAY);
		do begin
			exp_r.push_back('{32'h0, 32'h0, RESP_OKAY});
			axi_host_inst.rd(REG_STATUS, st);
		end while (st[ST_BUSY] === 1'b1);
	endtask
	task automatic wrap_up();
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			`CHK("rdata", exp_r[0].v & exp_r[0].m, rdata & exp_r[0].m)
			`CHK("rresp", exp_r[0].rs, rresp)
			void'(exp_r.pop_front());
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			`CHK("bresp", exp_b[0], bresp)
			void'(exp_b.pop_front());
		end
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_fail++;
			wrap_up();
		end
	end

	initial begin
		pc = 32'h0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(REG_PC, 32'hffff_ffff, 32'h0, RESP_OKAY);
		rd(REG_STATUS, 32'hffff_ffff, 32'h0, RESP_OKAY);
		rd(8'h14, 32'hffff_ffff, 32'h0, RESP_DECERR);
		wr(REG_INSTR, 32'h0, 4'h3, RESP_SLVERR);
		rd(REG_PC, 32'hffff_ffff, 32'h0, RESP_OKAY);
		$display("done: bus and reset");
		a = nxt();
		b = nxt();
		put(5'd1, a);
		put(5'd2, b);
		for (int i = 0; i < 2; i++) begin
			im = {i[0], 15'(nxt())};
			x = {{16{im[15]}}, im};
			issue(ins(OP_AND, 5'd3, 5'd1, {5'd2, 11'h0}));
			issue(ins(OP_ANDN, 5'd4, 5'd1, {5'd2, 11'h0}));
			issue(ins(OP_ANDI, 5'd5, 5'd1, im));
			issue(ins(OP_ANDNI, 5'd6, 5'd1, im));
			pc = pc + 32'h10;
			get(5'd3, a & b);
			get(5'd4, a & ~b);
			get(5'd5, a & x);
			get(5'd6, a & ~x);
			get(5'd2, b);
		end
		issue(ins(OP_IMM_PFX, 5'd0, 5'd0, im));
		issue(ins(OP_ANDI, 5'd7, 5'd1, 16'h0f0f));
		issue(ins(6'h3f, 5'd0, 5'd0, 16'h0));
		pc = pc + 32'hc;
		get(5'd7, a & {im, 16'h0f0f});
		rd(REG_PC, 32'hffff_ffff, pc, RESP_OKAY);
		rd(REG_STATUS, 32'h10, 32'h10, RESP_OKAY);
		wr(REG_STATUS, 32'h10, 4'hf, RESP_OKAY);
		rd(REG_STATUS, 32'h10, 32'h0, RESP_OKAY);
		$display("done: and family and prefix");
		// j[0] carry flag before, j[1] carry-use bit, j[2] keep-carry bit
		for (int j = 0; j < 8; j++) begin
			a = nxt();
			im = 16'(nxt());
			wr(REG_STATUS, {31'h0, j[0]}, 4'hf, RESP_OKAY);
			put(5'd1, a);
			issue(ins(OP_ADDI | {3'h0, j[2], j[1], 1'b0}, 5'd8, 5'd1, im));
			{co, x} = {1'b0, a} + {1'b0, {16{im[15]}}, im} + 33'(j[1] & j[0]);
			pc = pc + 32'h4;
			get(5'd8, x);
			rd(REG_STATUS, 32'h1, {31'h0, j[2] ? j[0] : co}, RESP_OKAY);
		end
		$display("done: add immediate carry");
		// k[0] taken, k[1] delay slot, k[2] immediate form, k[3] greater-or-equal
		for (int k = 0; k < 16; k++) begin
			tv = k[0] ? {29'h0, k[3], 2'h0} : (k[3] ? 32'hffff_ffff : 32'h5);
			off = k[2] ? 32'hffff_fff0 : (nxt() & 32'h0000_fffc);
			cond = k[3] ? COND_GE : COND_EQ;
			put(5'd11, tv);
			put(5'd2, off);
			put(5'd9, 32'h0);
			issue(ins(OP_ANDNI, 5'd1, 5'd11, 16'h0));
			pc = pc + 32'h4;
			tgt = pc + off;
			issue(ins(k[2] ? OP_BR_IMM : OP_BR_REG, {k[1], cond}, 5'd1, k[2] ? 16'hfff0 : {5'd2, 11'h0}));
			pc = (k[0] && !k[1]) ? tgt : pc + 32'h4;
			rd(REG_PC, 32'hffff_ffff, pc, RESP_OKAY);
			get(5'd1, tv);
			if (k[1]) begin
				issue(ins(OP_AND, 5'd9, 5'd2, {5'd2, 11'h0}));
				pc = k[0] ? tgt : pc + 32'h4;
				get(5'd9, off);
				rd(REG_PC, 32'hffff_ffff, pc, RESP_OKAY);
			end
		end
		$display("done: conditional branches");
		wrap_up();
	end
endmodule
`default_nettype wire
